// file: core/phy_autoneg_advertise_bits.sv
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "phy_adv_defs.svh"

module phy_autoneg_advertise_bits
  import phy_adv_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [15:0] adv_word_active,
  output logic restart_negotiation
);

  if (ADDR_W < 4 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie between 4 and 32");
  end

  // --------------------------------------------------
  // write channel
  // --------------------------------------------------
  wr_state_t wr_state_q, wr_state_d;
  logic aw_full_q, aw_full_d;
  logic w_full_q, w_full_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic awready_d, wready_d, bvalid_d;
  logic [1:0] bresp_d;
  logic wr_go;
  sel_t wr_sel;

  // address and data are caught separately, in either order
  always_comb begin
    wr_state_d = wr_state_q;
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    aw_addr_d = aw_addr_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid;
    bresp_d = bresp;
    wr_go = 1'b0;
    wr_sel = reg_sel(32'(aw_addr_q));
    case (wr_state_q)
      WR_COLLECT: begin
        if (awvalid && awready) begin
          aw_full_d = 1'b1;
          aw_addr_d = awaddr;
        end
        if (wvalid && wready) begin
          w_full_d = 1'b1;
          w_data_d = wdata;
          w_strb_d = wstrb;
        end
        if (aw_full_q && w_full_q) begin
          wr_go = 1'b1;
          aw_full_d = 1'b0;
          w_full_d = 1'b0;
          bvalid_d = 1'b1;
          bresp_d = (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
          wr_state_d = WR_RESP;
        end
      end
      WR_RESP: begin
        if (bready) begin
          bvalid_d = 1'b0;
          wr_state_d = WR_COLLECT;
        end
      end
      default: begin
        wr_state_d = WR_COLLECT;
      end
    endcase
    awready_d = (wr_state_d == WR_COLLECT) && !aw_full_d;
    wready_d = (wr_state_d == WR_COLLECT) && !w_full_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= WR_COLLECT;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      wr_state_q <= wr_state_d;
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready <= awready_d;
      wready <= wready_d;
      bvalid <= bvalid_d;
      bresp <= bresp_d;
    end
  end

  // --------------------------------------------------
  // register effects
  // --------------------------------------------------
  logic adv_wr;
  logic restart_req;
  adv_t adv_stored;

  assign adv_wr = wr_go && (wr_sel == SEL_ADV);
  // restart bit self-clears: it only ever exists as this pulse
  assign restart_req = wr_go && (wr_sel == SEL_CTRL)
                       && w_strb_q[`HI_LANE] && w_data_q[`RESTART_POS];

  adv_field_reg u_adv (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(adv_wr),
    .wdata(w_data_q),
    .wstrb(w_strb_q),
    .adv_q(adv_stored)
  );

  adv_commit u_commit (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart_req(restart_req),
    .adv_stored(adv_stored),
    .active_q(adv_word_active),
    .restart_q(restart_negotiation)
  );

  // --------------------------------------------------
  // read channel
  // --------------------------------------------------
  rd_state_t rd_state_q, rd_state_d;
  logic arready_d, rvalid_d;
  logic [31:0] rdata_d;
  logic [1:0] rresp_d;
  sel_t rd_sel;

  always_comb begin
    rd_state_d = rd_state_q;
    rvalid_d = rvalid;
    rdata_d = rdata;
    rresp_d = rresp;
    rd_sel = reg_sel(32'(araddr));
    case (rd_state_q)
      RD_IDLE: begin
        if (arvalid && arready) begin
          rvalid_d = 1'b1;
          rresp_d = `RESP_OKAY;
          rd_state_d = RD_RESP;
          case (rd_sel)
            SEL_ADV: rdata_d = {16'h0000, adv_to_word(adv_stored)};
            SEL_ACTIVE: rdata_d = {16'h0000, adv_word_active};
            SEL_CTRL: rdata_d = 32'h0000_0000;
            default: begin
              rdata_d = 32'h0000_0000;
              rresp_d = `RESP_SLVERR;
            end
          endcase
        end
      end
      RD_RESP: begin
        if (rready) begin
          rvalid_d = 1'b0;
          rd_state_d = RD_IDLE;
        end
      end
      default: begin
        rd_state_d = RD_IDLE;
      end
    endcase
    arready_d = (rd_state_d == RD_IDLE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= RD_IDLE;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      rd_state_q <= rd_state_d;
      arready <= arready_d;
      rvalid <= rvalid_d;
      rdata <= rdata_d;
      rresp <= rresp_d;
    end
  end

  // --------------------------------------------------
  // checks
  // --------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic wr_hi, wr_lo;
  assign wr_hi = adv_wr && w_strb_q[`HI_LANE];
  assign wr_lo = adv_wr && w_strb_q[`LO_LANE];

  property p_fault_write;
    wr_hi |=> adv_stored.remote_fault_adv == $past(w_data_q[`FAULT_POS]);
  endproperty
  a_fault_write: assert property (p_fault_write)
    else $error("remote fault bit did not take written value");

  property p_full100_write;
    wr_hi |=> adv_stored.adv_100tx_full == $past(w_data_q[`FULL100_POS]);
  endproperty
  a_full100_write: assert property (p_full100_write)
    else $error("100tx full bit did not take written value");

  property p_half100_write;
    wr_lo |=> adv_stored.adv_100_half == $past(w_data_q[`HALF100_POS]);
  endproperty
  a_half100_write: assert property (p_half100_write)
    else $error("100 half bit did not take written value");

  property p_full10_write;
    wr_lo |=> adv_stored.adv_10_full == $past(w_data_q[`FULL10_POS]);
  endproperty
  a_full10_write: assert property (p_full10_write)
    else $error("10 full bit did not take written value");

  property p_half10_write;
    wr_lo |=> adv_stored.adv_10_half == $past(w_data_q[`HALF10_POS]);
  endproperty
  a_half10_write: assert property (p_half10_write)
    else $error("10 half bit did not take written value");

  property p_adv_reset;
    !$past(aresetn) |-> adv_stored == `ADV_RESET
                        && adv_word_active == `ACTIVE_RESET;
  endproperty
  a_adv_reset: assert property (p_adv_reset)
    else $error("advertisement reset value wrong");

  property p_restart_commit;
    restart_req |=> restart_negotiation
                    && adv_word_active == adv_to_word($past(adv_stored));
  endproperty
  a_restart_commit: assert property (p_restart_commit)
    else $error("restart did not commit stored advertisement");

  property p_rsvd_read;
    arvalid && arready && rd_sel == SEL_ADV
      |=> rvalid && (rdata & `RSVD_MASK) == 32'h0000_0000;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved bits read non-zero");

  property p_hold_active;
    !restart_req |=> $stable(adv_word_active) && !restart_negotiation;
  endproperty
  a_hold_active: assert property (p_hold_active)
    else $error("active advertisement changed without restart");

  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before bready");

  property p_b_answer;
    wr_state_q == WR_COLLECT && aw_full_q && w_full_q |=> bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer)
    else $error("write response late");

  c_restart: cover property (restart_req ##1 restart_negotiation);
  c_clear_full100: cover property (wr_hi && !w_data_q[`FULL100_POS] ##[1:40] restart_req);
  c_bad_wr: cover property (bvalid && bresp == `RESP_SLVERR);
  c_read_adv: cover property (arvalid && arready && rd_sel == SEL_ADV);

endmodule : phy_autoneg_advertise_bits
`default_nettype wire

// file: core/phy_adv_defs.svh
// Summary of operation
// - remote fault bit 13, read-write, resets 0
// - 100TX full-duplex ability bit 8, resets 1
// - 100 half-duplex ability bit 7, resets 1
// - 10 full-duplex ability bit 6, resets 1
// - 10 half-duplex ability bit 5, resets 1
// - clear ability, restart, negotiate without it
// - bits 14, 12:9 read zero, ignore writes
`ifndef PHY_ADV_DEFS_SVH
`define PHY_ADV_DEFS_SVH

// --------------------------------------------------
// register map
// --------------------------------------------------
`define ADV_REG_OFFS 32'h0000_0000
`define CTRL_REG_OFFS 32'h0000_0004
`define ACTIVE_REG_OFFS 32'h0000_0008

// --------------------------------------------------
// field positions and lanes
// --------------------------------------------------
`define FAULT_POS 13
`define FULL100_POS 8
`define HALF100_POS 7
`define FULL10_POS 6
`define HALF10_POS 5
`define RESTART_POS 9
`define HI_LANE 1
`define LO_LANE 0
`define RSVD_MASK 32'h0000_5e00

// --------------------------------------------------
// reset values and responses
// --------------------------------------------------
`define ADV_RESET 5'h0f
`define ACTIVE_RESET 16'h01e0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: core/phy_adv_pkg.sv
`include "phy_adv_defs.svh"

package phy_adv_pkg;

  typedef struct packed {
    logic remote_fault_adv;
    logic adv_100tx_full;
    logic adv_100_half;
    logic adv_10_full;
    logic adv_10_half;
  } adv_t;

  typedef enum logic [1:0] {
    SEL_ADV = 2'h0,
    SEL_CTRL = 2'h1,
    SEL_ACTIVE = 2'h2,
    SEL_NONE = 2'h3
  } sel_t;

  typedef enum logic {
    WR_COLLECT = 1'b0,
    WR_RESP = 1'b1
  } wr_state_t;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } rd_state_t;

  function automatic sel_t reg_sel(logic [31:0] a);
    logic [31:0] w;
    w = {a[31:2], 2'h0};
    if (w == `ADV_REG_OFFS) return SEL_ADV;
    if (w == `CTRL_REG_OFFS) return SEL_CTRL;
    if (w == `ACTIVE_REG_OFFS) return SEL_ACTIVE;
    return SEL_NONE;
  endfunction : reg_sel

  function automatic logic [15:0] adv_to_word(adv_t a);
    logic [15:0] w;
    w = 16'h0000;
    w[`FAULT_POS] = a.remote_fault_adv;
    w[`FULL100_POS] = a.adv_100tx_full;
    w[`HALF100_POS] = a.adv_100_half;
    w[`FULL10_POS] = a.adv_10_full;
    w[`HALF10_POS] = a.adv_10_half;
    return w;
  endfunction : adv_to_word

endpackage : phy_adv_pkg

// file: core/adv_field_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "phy_adv_defs.svh"

module adv_field_reg
  import phy_adv_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output var adv_t adv_q
);

  adv_t adv_d;

  // reserved bits have no storage, so writes to them vanish
  always_comb begin
    adv_d = adv_q;
    if (wr_en && wstrb[`HI_LANE]) begin
      adv_d.remote_fault_adv = wdata[`FAULT_POS];
      adv_d.adv_100tx_full = wdata[`FULL100_POS];
    end
    if (wr_en && wstrb[`LO_LANE]) begin
      adv_d.adv_100_half = wdata[`HALF100_POS];
      adv_d.adv_10_full = wdata[`FULL10_POS];
      adv_d.adv_10_half = wdata[`HALF10_POS];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adv_q <= `ADV_RESET;
    end else begin
      adv_q <= adv_d;
    end
  end

endmodule : adv_field_reg
`default_nettype wire

// file: core/adv_commit.sv
`timescale 1ns/1ps
`default_nettype none
`include "phy_adv_defs.svh"

module adv_commit
  import phy_adv_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic restart_req,
  input wire adv_t adv_stored,
  output logic [15:0] active_q,
  output logic restart_q
);

  logic [15:0] active_d;
  logic restart_d;

  // the negotiation engine sees only this copy
  always_comb begin
    active_d = active_q;
    restart_d = restart_req;
    if (restart_req) begin
      active_d = adv_to_word(adv_stored);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_q <= `ACTIVE_RESET;
      restart_q <= 1'b0;
    end else begin
      active_q <= active_d;
      restart_q <= restart_d;
    end
  end

endmodule : adv_commit
`default_nettype wire

// file: tb/link_partner_model.sv
`timescale 1ns/1ps
`default_nettype none

module link_partner_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] adv_word,
  input wire logic restart,
  output logic got_q,
  output logic [15:0] seen_q,
  output logic stray_q
);
  logic [15:0] prev_q;

  // --------------------------------------------------
  // far side takes the offer only at a restart
  // --------------------------------------------------
  always_ff @(posedge aclk) begin
    prev_q <= adv_word;
    if (!aresetn) begin
      got_q <= 1'b0;
      seen_q <= 16'h0000;
      stray_q <= 1'b0;
    end else begin
      got_q <= restart;
      if (restart) begin
        seen_q <= adv_word;
      end
      // offer moving without a restart would reach the link early
      if (adv_word != prev_q && !restart) begin
        stray_q <= 1'b1;
      end
    end
  end
endmodule : link_partner_model

`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "phy_adv_defs.svh"

module tb
  import phy_adv_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, restart_negotiation, got, stray;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_last, v, cur;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] adv_word_active, seen;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [15:0] aq[$];
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;

  phy_autoneg_advertise_bits #(.ADDR_W(8)) dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .adv_word_active(adv_word_active),
    .restart_negotiation(restart_negotiation));

  link_partner_model partner (.aclk(aclk), .aresetn(aresetn),
    .adv_word(adv_word_active), .restart(restart_negotiation), .got_q(got),
    .seen_q(seen), .stray_q(stray));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // --------------------------------------------------
  // checking and bus tasks
  // --------------------------------------------------
  task automatic final_report;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic cmp(input logic [33:0] got_v, input logic [33:0] exp_v);
    compares++;
    if (got_v !== exp_v) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask : cmp

  task automatic cmp_rd(input logic [33:0] got_v);
    cmp(got_v, rq.size() ? rq.pop_front() : ~got_v);
  endtask : cmp_rd

  task automatic cmp_b(input logic [1:0] got_v);
    cmp(34'(got_v), bq.size() ? 34'(bq.pop_front()) : ~34'(got_v));
  endtask : cmp_b

  task automatic cmp_adv(input logic [15:0] got_v);
    cmp(34'(got_v), aq.size() ? 34'(aq.pop_front()) : ~34'(got_v));
  endtask : cmp_adv

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] e);
    bq.push_back(e);
    awaddr <= a[7:0];
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!bvalid);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
    rq.push_back({r, e});
    araddr <= a[7:0];
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd_last = rdata;
  endtask : rd

  task automatic restart(input logic [15:0] e);
    aq.push_back(e);
    wr(`CTRL_REG_OFFS, 32'h1 << `RESTART_POS, 4'hf, `RESP_OKAY);
  endtask : restart

  // an empty queue compares against the inverse, so a stray result fails
  always @(posedge aclk) begin
    cyc++;
    if (rvalid && rready) cmp_rd({rresp, rdata});
    if (bvalid && bready) cmp_b(bresp);
    if (got) cmp_adv(seen);
    if (cyc == 5000) begin
      num_errors++;
      final_report();
    end
  end

  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, arvalid, bready, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    void'($urandom(32'h0e9a2684));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    bready <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    rd(`ADV_REG_OFFS, 32'h1e0, `RESP_OKAY);
    rd(`ACTIVE_REG_OFFS, 32'h1e0, `RESP_OKAY);
    wr(`ADV_REG_OFFS, 32'hffff_ffff, 4'hf, `RESP_OKAY);
    rd(`ADV_REG_OFFS, 32'h21e0, `RESP_OKAY);
    rd(`ACTIVE_REG_OFFS, 32'h1e0, `RESP_OKAY);
    wr(`CTRL_REG_OFFS, 32'h200, 4'h1, `RESP_OKAY);
    restart(16'h21e0);
    rd(`ACTIVE_REG_OFFS, 32'h21e0, `RESP_OKAY);
    cur = 32'h21e0;
    for (int i = 5; i <= 13; i++) begin
      if (i > 8 && i < 13) continue;
      rd(`ADV_REG_OFFS, cur, `RESP_OKAY);
      cur = cur & ~(32'h1 << i);
      wr(`ADV_REG_OFFS, rd_last & ~(32'h1 << i), 4'hf, `RESP_OKAY);
      restart(cur[15:0]);
    end
    for (int k = 0; k < 8; k++) begin
      v = $urandom;
      wr(`ADV_REG_OFFS, v, 4'hf, `RESP_OKAY);
      rd(`ADV_REG_OFFS, v & 32'h21e0, `RESP_OKAY);
      restart(v[15:0] & 16'h21e0);
    end
    // lane 0 holds the three low abilities, lane 1 the rest
    wr(`ADV_REG_OFFS, 32'h0, 4'h1, `RESP_OKAY);
    rd(`ADV_REG_OFFS, v & 32'h2100, `RESP_OKAY);
    wr(`ADV_REG_OFFS, 32'h0, 4'h2, `RESP_OKAY);
    rd(`ADV_REG_OFFS, 32'h0, `RESP_OKAY);
    wr(32'h0c, 32'hffff_ffff, 4'hf, `RESP_SLVERR);
    rd(32'h0c, 32'h0, `RESP_SLVERR);
    wr(`ACTIVE_REG_OFFS, 32'h0, 4'hf, `RESP_OKAY);
    rd(`ACTIVE_REG_OFFS, v & 32'h21e0, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    // reset clears the stray flag, so look before it
    cmp(34'(stray), 34'h0);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`ADV_REG_OFFS, 32'h1e0, `RESP_OKAY);
    rd(`ACTIVE_REG_OFFS, 32'h1e0, `RESP_OKAY);
    repeat (4) @(posedge aclk);
    cmp(34'(stray), 34'h0);
    cmp(34'(rq.size() + bq.size() + aq.size()), 34'h0);
    final_report();
  end
endmodule : tb

`default_nettype wire
